// >>> core/vdc_defines.svh
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH

// byte addresses of the control word, its aliases and the interrupt and module-disable registers
`define VDC_OFS_CTRL 8'h00
`define VDC_OFS_CLR 8'h04
`define VDC_OFS_SET 8'h08
`define VDC_OFS_INV 8'h0c
`define VDC_OFS_IRQ_STAT 8'h10
`define VDC_OFS_IRQ_MASK 8'h14
`define VDC_OFS_MODDIS 8'h18

// control word fields
`define VDC_BIT_ENABLE 15
`define VDC_BIT_DIR 11
`define VDC_BIT_BGSTABLE 10
`define VDC_BIT_RSVD_ONE 9
`define VDC_BIT_EVENT 8
`define VDC_BIT_OUTGATE 7
`define VDC_LVL_LSB 0
`define VDC_LVL_MSB 3

// software-writable bits of the control word
`define VDC_CTRL_WMASK 32'h0000_888f
`define VDC_CTRL_RESET 32'h0000_0000
`define VDC_LVL_EXTERNAL 4'hf
`define VDC_LVL_MIN_INTERNAL 4'h4

// interrupt status bits
`define VDC_IRQ_EVENT 0
`define VDC_IRQ_BGLOST 1
`define VDC_IRQ_W 2

`endif

// >>> core/vdc_pkg.sv
package vdc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } vdc_bus_req_t;

   typedef struct packed {
      logic enable;
      logic trip_above;
      logic use_external;
      logic [3:0] trip_level;
   } vdc_analog_cfg_t;

   typedef enum logic [2:0] {
      VDC_IDLE = 3'b001,
      VDC_ARMED = 3'b010,
      VDC_EVENT = 3'b100
   } vdc_state_t;

endpackage : vdc_pkg

// >>> core/vdc_voltage_detect.sv
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Function
// RULE1: bit 15 of the control word enables the detector when one and disables it when zero.
// RULE2: with the direction bit at one, an event is declared when the voltage reaches or exceeds the trip level.
// RULE3: with the direction bit at zero, an event is declared when the voltage reaches or falls below the trip level; the code fires only strictly below it.
// RULE4: bit 10 is a read-only band-gap stable flag set and cleared by hardware, readable even while disabled.
// RULE5: bit 8 is a read-only flag set and cleared by hardware, one while a detection event is active.
// RULE6: bit 9 is reserved and always reads one.
// RULE7: bit 7 gates the event output, one lets it out and zero suppresses it.
// RULE8: once bit 7 is one a written zero cannot clear it; only an enable change or the module-disable control can.
// RULE9: trip-level code 1111 selects the external input, 1110 to 0100 internal levels, 0011 and below are reserved.
// RULE10: software should change settings only while the detector is disabled.
// RULE11: bits 31-16, 14-12 and 6-4 ignore writes and read as zero.
// RULE12: clear, set and invert aliases sit at base plus 0x4, 0x8 and 0xc.
// RULE13: a detection event can raise a non-maskable interrupt request.
// RULE14: the comparator and band-gap signals pass a two-stage synchroniser before they update status.
`include "vdc_defines.svh"

module vdc_voltage_detect (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire vdc_pkg::vdc_bus_req_t bus_req_i,
   output logic [31:0] bus_rdata_o,
   input wire logic cmp_trip_i,
   input wire logic bandgap_stable_i,
   input wire logic module_disable_control_i,
   output vdc_pkg::vdc_analog_cfg_t analog_cfg_o,
   output logic event_out_o,
   output logic nmi_req_o,
   output logic irq_o
);
   import vdc_pkg::*;

   logic [31:0] ctrl_ff;
   logic [31:0] nxt_ctrl;
   logic [1:0] cmp_sync_ff;
   logic [1:0] bg_sync_ff;
   logic event_ff;
   logic nxt_event;
   logic bg_stable_ff;
   logic [`VDC_IRQ_W-1:0] irq_stat_ff;
   logic [`VDC_IRQ_W-1:0] nxt_irq_stat;
   logic [`VDC_IRQ_W-1:0] irq_mask_ff;
   logic moddis_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic nmi_ff;
   vdc_state_t state_ff;
   vdc_state_t nxt_state;

   // next values of the gate bit and of the status clear mask
   logic nxt_gate;
   logic [`VDC_IRQ_W-1:0] stat_clr;

   // applies a bus write to the writable bits of the control word
   function automatic logic [31:0] ctrl_write(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [7:0] ofs);
      logic [31:0] res;
      res = cur;
      case (ofs)
         `VDC_OFS_CTRL: res = wd;
         `VDC_OFS_CLR: res = cur & ~wd;
         `VDC_OFS_SET: res = cur | wd;
         `VDC_OFS_INV: res = cur ^ wd;
         default: res = cur;
      endcase
      return (res & `VDC_CTRL_WMASK) | (cur & ~`VDC_CTRL_WMASK); // RULE11
   endfunction : ctrl_write

   // the four control-word aliases share one decode
   function automatic logic is_ctrl_ofs(input logic [7:0] ofs);
      logic hit;
      hit = 1'b0;
      case (ofs)
         `VDC_OFS_CTRL: hit = 1'b1;
         `VDC_OFS_CLR: hit = 1'b1;
         `VDC_OFS_SET: hit = 1'b1;
         `VDC_OFS_INV: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : is_ctrl_ofs

   // reserved codes never arm; a misprogrammed level must not fire events
   function automatic logic level_armable(input logic [3:0] lvl);
      return (lvl >= `VDC_LVL_MIN_INTERNAL);
   endfunction : level_armable

   // comparator reads one at or above the level; direction picks the polarity
   function automatic logic trip_met(input logic dir_up, input logic cmp);
      logic met;
      met = dir_up ? cmp : ~cmp;
      return met;
   endfunction : trip_met

   // set beats a simultaneous write-one-to-clear so no event is lost
   function automatic logic [`VDC_IRQ_W-1:0] stat_update(input logic [`VDC_IRQ_W-1:0] cur,
                                                           input logic [`VDC_IRQ_W-1:0] clr,
                                                           input logic [`VDC_IRQ_W-1:0] set);
      return (cur & ~clr) | set;
   endfunction : stat_update

   // interrupt registers read back zero-extended
   function automatic logic [31:0] zext_irq(input logic [`VDC_IRQ_W-1:0] v);
      return {{(32-`VDC_IRQ_W){1'b0}}, v};
   endfunction : zext_irq

   wire en_w = clk_en_i;
   wire wr_w = bus_req_i.wr;
   wire rd_w = bus_req_i.rd;
   wire [7:0] addr_w = bus_req_i.addr;
   wire [31:0] wdata_w = bus_req_i.wdata;
   wire ctrl_hit_w = is_ctrl_ofs(addr_w); // RULE12
   wire moddis_wr_w = wr_w && (addr_w == `VDC_OFS_MODDIS);
   wire mask_wr_w = wr_w && (addr_w == `VDC_OFS_IRQ_MASK);
   wire ctrl_wr_w = wr_w && ctrl_hit_w;
   wire [31:0] ctrl_cand_w = ctrl_write(ctrl_ff, bus_req_i.wdata, addr_w);

   wire enable_w = ctrl_ff[`VDC_BIT_ENABLE]; // RULE1
   wire dir_up_w = ctrl_ff[`VDC_BIT_DIR];
   wire [3:0] level_w = ctrl_ff[`VDC_LVL_MSB:`VDC_LVL_LSB];
   wire level_ext_w = (level_w == `VDC_LVL_EXTERNAL); // RULE9
   wire level_ok_w = level_armable(level_w); // RULE9
   // the module-disable register parks the detector as well as the analog side
   wire run_w = enable_w && !moddis_ff; // RULE1
   wire arm_ok_w = run_w && level_ok_w;
   wire enable_chg_w = ctrl_wr_w && (ctrl_cand_w[`VDC_BIT_ENABLE] != enable_w);

   // cmp_trip_i is the raw comparator: one when voltage is at or above the level
   wire cmp_s_w = cmp_sync_ff[1];
   wire trip_hit_w = trip_met(dir_up_w, cmp_s_w); // RULE2 RULE3

   // gate bit: writes may only raise it; enable change or module disable clears it
   wire gate_clr_w = enable_chg_w || moddis_ff || module_disable_control_i; // RULE8

   always_comb begin
      nxt_gate = ctrl_ff[`VDC_BIT_OUTGATE];
      if (gate_clr_w) begin
         nxt_gate = 1'b0; // RULE8
      end else if (ctrl_wr_w && ctrl_cand_w[`VDC_BIT_OUTGATE]) begin
         nxt_gate = 1'b1;
      end
   end

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (ctrl_wr_w) begin
         nxt_ctrl = ctrl_cand_w;
      end
      nxt_ctrl[`VDC_BIT_OUTGATE] = nxt_gate; // RULE8
   end

   // event is a level that follows the condition, not a latched flag
   always_comb begin
      nxt_state = state_ff;
      nxt_event = event_ff;
      case (state_ff)
         VDC_IDLE: begin
            nxt_event = 1'b0;
            if (arm_ok_w) begin
               nxt_state = VDC_ARMED;
            end else begin
               nxt_state = VDC_IDLE;
            end
         end
         VDC_ARMED: begin
            if (!arm_ok_w) begin
               nxt_state = VDC_IDLE;
               nxt_event = 1'b0;
            end else if (trip_hit_w) begin
               nxt_state = VDC_EVENT;
               nxt_event = 1'b1; // RULE5
            end else begin
               nxt_state = VDC_ARMED;
               nxt_event = 1'b0;
            end
         end
         VDC_EVENT: begin
            if (!arm_ok_w) begin
               nxt_state = VDC_IDLE;
               nxt_event = 1'b0;
            end else if (!trip_hit_w) begin
               nxt_state = VDC_ARMED;
               nxt_event = 1'b0; // RULE5
            end else begin
               nxt_state = VDC_EVENT;
               nxt_event = 1'b1;
            end
         end
         default: begin
            nxt_state = VDC_IDLE;
            nxt_event = 1'b0;
         end
      endcase
   end

   wire event_rise_w = nxt_event && !event_ff;
   wire bg_fall_w = bg_stable_ff && !bg_sync_ff[1];
   wire stat_wr_w = wr_w && (addr_w == `VDC_OFS_IRQ_STAT);
   wire [`VDC_IRQ_W-1:0] stat_set_w = {bg_fall_w, event_rise_w};

   // a status write clears only the bits written as one
   always_comb begin
      stat_clr = '0;
      if (stat_wr_w) begin
         stat_clr = wdata_w[`VDC_IRQ_W-1:0];
      end
   end

   always_comb begin
      nxt_irq_stat = stat_update(irq_stat_ff, stat_clr, stat_set_w);
   end

   // read view rebuilt from fields so unused bits stay zero
   wire [3:0] rd_hi_w = {ctrl_ff[`VDC_BIT_ENABLE], 3'h0}; // RULE11
   wire [3:0] rd_status_w = {dir_up_w, bg_stable_ff, 1'b1, event_ff}; // RULE4 RULE5 RULE6
   wire [3:0] rd_gate_w = {ctrl_ff[`VDC_BIT_OUTGATE], 3'h0}; // RULE11
   wire [31:0] ctrl_rd_w = {16'h0000, rd_hi_w, rd_status_w, rd_gate_w, level_w};
   wire [31:0] stat_rd_w = zext_irq(irq_stat_ff);
   wire [31:0] mask_rd_w = zext_irq(irq_mask_ff);
   wire [31:0] moddis_rd_w = {31'h0000_0000, moddis_ff};

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (addr_w)
         `VDC_OFS_IRQ_STAT: nxt_rdata = stat_rd_w;
         `VDC_OFS_IRQ_MASK: nxt_rdata = mask_rd_w;
         `VDC_OFS_MODDIS: nxt_rdata = moddis_rd_w;
         default: nxt_rdata = is_ctrl_ofs(addr_w) ? ctrl_rd_w : 32'h0000_0000;
      endcase
   end

   // two-stage synchronisers for the asynchronous analog outputs
   // only the second stage feeds logic
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cmp_sync_ff <= 2'h0;
      end else if (en_w) begin
         cmp_sync_ff <= {cmp_sync_ff[0], cmp_trip_i}; // RULE14
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bg_sync_ff <= 2'h0;
      end else if (en_w) begin
         bg_sync_ff <= {bg_sync_ff[0], bandgap_stable_i}; // RULE14
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl_ff <= `VDC_CTRL_RESET;
      end else if (en_w) begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // register twin of the disable pin; also parks the detector
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         moddis_ff <= 1'b0;
      end else if (en_w && moddis_wr_w) begin
         moddis_ff <= wdata_w[0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         irq_mask_ff <= '0;
      end else if (en_w && mask_wr_w) begin
         irq_mask_ff <= wdata_w[`VDC_IRQ_W-1:0];
      end
   end

   // flag reflects the band gap regardless of enable
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bg_stable_ff <= 1'b0;
      end else if (en_w) begin
         bg_stable_ff <= bg_sync_ff[1]; // RULE4
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_ff <= VDC_IDLE;
      end else if (en_w) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         event_ff <= 1'b0;
      end else if (en_w) begin
         event_ff <= nxt_event;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         irq_stat_ff <= '0;
      end else if (en_w) begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // nmi ignores the output gate, which only governs the event pin
   wire nmi_nxt_w = nxt_event && run_w; // RULE13
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         nmi_ff <= 1'b0;
      end else if (en_w) begin
         nmi_ff <= nmi_nxt_w;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (en_w && rd_w) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // the module-disable register also holds the analog parts powered down
   assign analog_cfg_o.enable = enable_w && !moddis_ff; // RULE1
   assign analog_cfg_o.trip_above = dir_up_w;
   assign analog_cfg_o.use_external = level_ext_w; // RULE9
   assign analog_cfg_o.trip_level = level_w;
   wire event_out_w = event_ff && ctrl_ff[`VDC_BIT_OUTGATE]; // RULE7
   // interrupt line is a plain level; status stays sticky until written
   wire irq_pend_w = |(irq_stat_ff & irq_mask_ff);
   assign event_out_o = event_out_w;
   assign nmi_req_o = nmi_ff;
   assign irq_o = irq_pend_w;
   assign bus_rdata_o = rdata_ff;

endmodule : vdc_voltage_detect

// >>> verif/vdc_analog_model.sv
`timescale 1ns/100ps
module vdc_analog_model (
   input wire logic clock_i,
   input wire vdc_pkg::vdc_analog_cfg_t cfg_i,
   input wire logic [3:0] volt_i,
   input wire logic ext_i,
   input wire logic bg_i,
   input wire logic slow_i,
   output logic cmp_trip_o,
   output logic bandgap_stable_o
);
   import vdc_pkg::*;
   logic raw;
   logic late_ff;
   // code 1111 follows the external input, the rest the supply level
   assign raw = cfg_i.use_external ? ext_i : (volt_i >= cfg_i.trip_level);
   always_ff @(posedge clock_i) late_ff <= raw;
   // powered-down comparator idles low; slow mode settles one cycle late
   assign cmp_trip_o = cfg_i.enable & (slow_i ? late_ff : raw);
   assign bandgap_stable_o = bg_i;
endmodule : vdc_analog_model

// >>> verif/vdc_monitor.sv
`timescale 1ns/100ps
module vdc_monitor (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire vdc_pkg::vdc_bus_req_t bus_req_i,
   input wire logic [31:0] bus_rdata_o,
   input wire logic cmp_trip_i,
   input wire logic bandgap_stable_i,
   input wire logic module_disable_control_i,
   input wire vdc_pkg::vdc_analog_cfg_t analog_cfg_o,
   input wire logic event_out_o,
   input wire logic nmi_req_o,
   input wire logic irq_o
);
   import vdc_pkg::*;
   wire rd0 = clk_en_i & bus_req_i.rd & (bus_req_i.addr <= 8'h0c);
   wire en = analog_cfg_o.enable;
   wire armed = clk_en_i & en & (analog_cfg_o.trip_level >= 4'h4);
   wire up = analog_cfg_o.trip_above;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   property p_off; !en [*3] |-> !nmi_req_o && !event_out_o; endproperty
   a_off: assert property (p_off) else $error("event while disabled");
   property p_up; (armed & up & cmp_trip_i) [*6] |-> nmi_req_o; endproperty
   a_up: assert property (p_up) else $error("rising trip missed");
   property p_dn; (armed & !up & !cmp_trip_i) [*6] |-> nmi_req_o; endproperty
   a_dn: assert property (p_dn) else $error("falling trip missed");
   property p_rsv; (clk_en_i & en & (analog_cfg_o.trip_level < 4'h4)) [*3] |-> !nmi_req_o; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved level armed");
   property p_ext; analog_cfg_o.use_external == (analog_cfg_o.trip_level == 4'hf); endproperty
   a_ext: assert property (p_ext) else $error("external select wrong");
   property p_gate; $rose(event_out_o) |-> $past(en); endproperty
   a_gate: assert property (p_gate) else $error("event out without enable");
   property p_evt; rd0 & nmi_req_o |=> bus_rdata_o[8]; endproperty
   a_evt: assert property (p_evt) else $error("event flag low");
   property p_one; rd0 |=> bus_rdata_o[9]; endproperty
   a_one: assert property (p_one) else $error("reserved bit not one");
   property p_zero; rd0 |=> bus_rdata_o[31:16] == 16'h0 && bus_rdata_o[14:12] == 3'h0 && bus_rdata_o[6:4] == 3'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("unused bits not zero");
   property p_bg; bandgap_stable_i [*4] ##0 rd0 |=> bus_rdata_o[10]; endproperty
   a_bg: assert property (p_bg) else $error("band gap flag low");
   c_nmi: cover property ($rose(nmi_req_o));
   c_out: cover property ($rose(event_out_o));
   c_irq: cover property ($rose(irq_o));
endmodule : vdc_monitor

bind vdc_voltage_detect vdc_monitor u_mon (.clock_i, .sys_rst_i, .clk_en_i, .bus_req_i, .bus_rdata_o, .cmp_trip_i,
   .bandgap_stable_i, .module_disable_control_i, .analog_cfg_o, .event_out_o, .nmi_req_o, .irq_o);

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
   import vdc_pkg::*;
   logic clock_i, sys_rst_i, clk_en_i, cmp, bg, mdc, evo, nmi, irq, ext, bgi, slow;
   logic [31:0] rdata;
   logic [3:0] volt;
   vdc_bus_req_t req;
   vdc_analog_cfg_t cfg;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   vdc_voltage_detect uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .bus_req_i(req),
      .bus_rdata_o(rdata), .cmp_trip_i(cmp), .bandgap_stable_i(bg), .module_disable_control_i(mdc),
      .analog_cfg_o(cfg), .event_out_o(evo), .nmi_req_o(nmi), .irq_o(irq));
   vdc_analog_model u_ana (.clock_i(clock_i), .cfg_i(cfg), .volt_i(volt), .ext_i(ext), .bg_i(bgi),
      .slow_i(slow), .cmp_trip_o(cmp), .bandgap_stable_o(bg));
   task summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] s, input logic [31:0] e, input string n);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clock_i);
   endtask : wt
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_i);
      req.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge clock_i);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock_i);
      req.rd <= 1'b0;
      #1 chk(rdata, e, n);
   endtask : rd
   initial begin
      clock_i = 0;
      forever #4 clock_i = ~clock_i;
   end
   // hang guard, generous against roughly 120 cycles of traffic
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      sys_rst_i = 1; clk_en_i = 1; req = '0; mdc = 0; volt = 4'h9; ext = 0; bgi = 1; slow = 0;
      wt(4);
      sys_rst_i <= 0;
      wt(4);
      rd(8'h00, 32'h0000_0600, "ctrl reset");
      bgi <= 0;
      wt(5);
      rd(8'h00, 32'h0000_0200, "bg lost");
      bgi <= 1;
      wr(8'h00, 32'hffff_7fff);
      rd(8'h00, 32'h0000_0e8f, "ctrl mask");
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0000_0680, "gate hold");
      wr(8'h08, 32'h0000_0805);
      rd(8'h00, 32'h0000_0e85, "set alias");
      wr(8'h04, 32'h0000_0001);
      rd(8'h04, 32'h0000_0e84, "clr alias");
      wr(8'h0c, 32'h0000_0803);
      rd(8'h0c, 32'h0000_0687, "inv alias");
      wr(8'h08, 32'h0000_8000);
      rd(8'h00, 32'h0000_8607, "enable");
      volt <= 4'h3;
      wt(8);
      @(negedge clock_i) chk({31'h0, nmi}, 32'h1, "nmi below");
      chk({31'h0, evo}, 32'h0, "out gated");
      rd(8'h00, 32'h0000_8707, "event flag");
      wr(8'h08, 32'h0000_0080);
      @(negedge clock_i) chk({31'h0, evo}, 32'h1, "out open");
      rd(8'h10, 32'h0000_0003, "irq stat");
      wr(8'h14, 32'h0000_0001);
      @(negedge clock_i) chk({31'h0, irq}, 32'h1, "irq on");
      wr(8'h10, 32'h0000_0003);
      @(negedge clock_i) chk({31'h0, irq}, 32'h0, "irq clear");
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0, "unmapped");
      mdc <= 1;
      wt(1);
      mdc <= 0;
      rd(8'h00, 32'h0000_8707, "moddis");
      wr(8'h18, 32'h0000_0001);
      rd(8'h18, 32'h0000_0001, "moddis reg");
      @(negedge clock_i) chk({31'h0, nmi}, 32'h0, "moddis parks");
      chk({31'h0, cfg.enable}, 32'h0, "moddis analog");
      wr(8'h18, 32'h0);
      wt(4);
      clk_en_i <= 0;
      wr(8'h04, 32'h0000_8000);
      clk_en_i <= 1;
      rd(8'h00, 32'h0000_8707, "frozen");
      wr(8'h04, 32'h0000_8000);
      wt(3);
      @(negedge clock_i) chk({31'h0, nmi}, 32'h0, "nmi off");
      wr(8'h08, 32'h0000_0808);
      wr(8'h08, 32'h0000_8000);
      slow <= 1;
      wt(6);
      @(negedge clock_i) chk({31'h0, nmi}, 32'h0, "ext low");
      ext <= 1;
      wt(8);
      @(negedge clock_i) chk({31'h0, nmi}, 32'h1, "ext high");
      wr(8'h04, 32'h0000_8000);
      wr(8'h04, 32'h0000_000d);
      wr(8'h08, 32'h0000_8000);
      wt(8);
      @(negedge clock_i) chk({31'h0, nmi}, 32'h0, "reserved");
      summarize();
   end
endmodule : tb
